// ===== core/debug_access_authentication.sv
// Summary of operation
// RULE_01: Exact 128-bit key match grants debug access.
// RULE_02: Probe sets debugger enable after passing.
// RULE_03: Stored unlock code resets to all ones.
// RULE_04: Debug entry only operating/sleep, boost or full-power normal.
// RULE_05: Boost-normal moves refused; back-bias emulated.
// RULE_06: Probe sets debugger enable before low power.
// RULE_07: Low power modes allowed during debug.
// RULE_08: Wake request wakes; halt keeps CPU stopped.
// RULE_09: Bus access only awake, stable mode.
// RULE_10: New unlock code applies after reset.
// RULE_11: Key rewrite blocks software system reset.
// RULE_12: Probe loads new code before reset.
// RULE_13: Compare waits fixed time after reset.
// RULE_14: Code MSB zero always refuses.
// RULE_15: All-ones code grants access keylessly.
// RULE_16: Erase key plus reset erases flash.
// RULE_17: Probe requests debug power, awaits acknowledge.
// RULE_18: System port is 0, register port 1.
// RULE_19: Probe writes full key before system port.
// RULE_20: Result shown in status and port bits.
// RULE_21: Probe writes key words in ascending order.
// RULE_22: Status bits: authentication_flag, sleep, clock stopped.
// RULE_23: Halt bit clears when CPU halts.
// RULE_24: Result held until key rewrite or reset.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module debug_access_authentication
  import dbg_authentication_flag_pkg::*;
#(
  parameter logic [127:0] UNLOCK_DEFAULT = 128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF
) (
  input  wire  logic                    clock,
  input  wire  logic                    reset_n,
  input  wire  dbg_authentication_flag_pkg::reg_req_s  req,
  output logic [31:0]                   rdata,
  input  wire  logic [127:0]            programmed_code,
  input  wire  logic                    program_pending,
  input  wire  logic                    cpu_sleeping,
  input  wire  logic                    cpu_halted,
  input  wire  logic                    erase_done,
  input  wire  logic                    power_up_request,
  input  wire  logic                    sw_reset_request,
  input  wire  logic                    mode_change_request,
  input  wire  dbg_authentication_flag_pkg::power_ctrl_e mode_change_target,
  input  wire  dbg_authentication_flag_pkg::chip_mode_s  mode,
  input  wire  logic                    debug_entry_request,
  output logic                          debug_mode,
  output logic                          authentication_flag,
  output logic                          ahb_port_enable,
  output logic                          system_bus_enable,
  output logic                          external_halt_request,
  output logic                          debug_interrupt_request,
  output logic                          wake_without_execute,
  output logic                          power_up_ack,
  output logic                          sw_reset_out,
  output logic                          mode_change_grant,
  output logic                          erase_start,
  output logic                          keep_normal_power
);
  import dbg_authentication_flag_pkg::*;

  logic [3:0]   pin_sync;
  logic         sleep_s;
  logic         halted_s;
  logic         erase_s;
  logic         pwrreq_s;
  logic         entry_ok;
  logic         bus_ok;
  logic [31:0]  key_reg [KEY_WORDS];
  logic [127:0] key_flat;
  logic [127:0] unlock_reg;
  logic         key_written_reg;
  logic         compare_due_reg;
  logic [15:0]  wait_cnt_reg;
  logic         wait_done;
  logic         erase_pending_reg;
  logic         match;
  logic         wr_ctrl;

  dbg_sync #(.WIDTH(4)) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in ({cpu_sleeping, cpu_halted, erase_done, power_up_request}),
    .sync_out (pin_sync)
  );
  assign {sleep_s, halted_s, erase_s, pwrreq_s} = pin_sync;

  dbg_mode_gate u_gate (
    .mode     (mode),
    .entry_ok (entry_ok),
    .bus_ok   (bus_ok)
  );

  function automatic logic is_key_addr(input logic [11:0] a, input int idx);
    return a == (KEY_ENTRY_WORD0_OFS + 12'(idx * 256));
  endfunction : is_key_addr

  assign key_flat = {key_reg[0], key_reg[1], key_reg[2], key_reg[3]};
  assign wr_ctrl  = req.write && req.addr == DEBUG_CONTROL_OFS;

  // Key-entry words, write only.
  for (genvar g = 0; g < KEY_WORDS; g++) begin : g_key
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        key_reg[g] <= KEY_WORD_RESET;
      end else if (req.write && is_key_addr(req.addr, g)) begin
        key_reg[g] <= req.wdata;
      end
    end
  end

  // Unlock code is latched once after reset release, so changes only act after reset.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      unlock_reg      <= UNLOCK_CODE_RESET; // [RULE_03]
      compare_due_reg <= 1'b1;
    end else if (compare_due_reg && wait_done) begin
      unlock_reg      <= program_pending ? programmed_code : UNLOCK_DEFAULT; // [RULE_10]
      compare_due_reg <= 1'b0;
    end
  end

  // Startup wait before any comparison.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt_reg <= '0;
    end else if (!wait_done) begin
      wait_cnt_reg <= wait_cnt_reg + 16'h0001; // [RULE_13]
    end
  end
  assign wait_done = wait_cnt_reg >= 16'(COMPARE_WAIT_CYC);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      key_written_reg <= 1'b0;
    end else if (req.write && req.addr <= KEY_ENTRY_WORD3_OFS && req.addr[7:0] == 8'h00) begin
      key_written_reg <= 1'b1; // [RULE_11]
    end
  end

  assign match = (key_flat == unlock_reg) && unlock_reg[KEY_MSB]; // [RULE_01] [RULE_14]

  // Result flag, recomputed on every key write and held in between.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      authentication_flag <= 1'b0;
    end else if (!wait_done || compare_due_reg) begin
      authentication_flag <= 1'b0; // [RULE_13]
    end else if (!unlock_reg[KEY_MSB]) begin
      authentication_flag <= 1'b0; // [RULE_14]
    end else if (unlock_reg == UNLOCK_CODE_RESET) begin
      authentication_flag <= 1'b1; // [RULE_15]
    end else if (!key_written_reg || match) begin
      authentication_flag <= match; // [RULE_24]
    end else begin
      authentication_flag <= match; // [RULE_01]
    end
  end

  // Debug mode entry allowed only from stable operating/sleep states in boost or full-power normal.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      debug_mode <= 1'b0;
    end else if (debug_entry_request && entry_ok && !debug_mode) begin
      debug_mode <= 1'b1; // [RULE_04]
    end
  end

  // Port 0 (system space) gated by result only, bus by result, debug mode and chip mode; port 1 always open.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ahb_port_enable   <= 1'b0;
      system_bus_enable <= 1'b0;
    end else begin
      ahb_port_enable   <= authentication_flag; // [RULE_18] [RULE_20]
      system_bus_enable <= authentication_flag && debug_mode && bus_ok; // [RULE_09] [RULE_07]
    end
  end

  // Power control transitions during debug mode.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_change_grant <= 1'b0;
      keep_normal_power <= 1'b0;
    end else begin
      mode_change_grant <= mode_change_request &&
        !(debug_mode && ((mode.power_ctrl == PCM_BOOST && mode_change_target == PCM_NORMAL) ||
                         (mode.power_ctrl == PCM_NORMAL && mode_change_target == PCM_BOOST))); // [RULE_05]
      keep_normal_power <= debug_mode && mode.power_ctrl == PCM_BACK_BIAS; // [RULE_05]
    end
  end

  // Halt request clears when CPU halts; set wins over the halt clear.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      external_halt_request <= 1'b0;
    end else if (wr_ctrl) begin
      external_halt_request <= req.wdata[CTRL_HALT_BIT]; // [RULE_23]
    end else if (halted_s) begin
      external_halt_request <= 1'b0; // [RULE_23]
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      debug_interrupt_request <= 1'b0;
      wake_without_execute    <= 1'b0;
    end else if (wr_ctrl) begin
      debug_interrupt_request <= req.wdata[CTRL_WAKE_BIT]; // [RULE_08]
      wake_without_execute    <= req.wdata[CTRL_WAKE_BIT] && req.wdata[CTRL_HALT_BIT]; // [RULE_08]
    end
  end

  // Software reset passes through unless keys were rewritten.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sw_reset_out <= 1'b0;
    end else begin
      sw_reset_out <= sw_reset_request && !key_written_reg; // [RULE_11]
    end
  end

  // Erase on the reset that follows an erase key.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      erase_pending_reg <= 1'b0;
      erase_start       <= 1'b0;
    end else begin
      erase_pending_reg <= compare_due_reg && wait_done && program_pending &&
                           programmed_code == ERASE_KEY; // [RULE_16]
      erase_start       <= erase_pending_reg; // [RULE_16]
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      power_up_ack <= 1'b0;
    end else begin
      power_up_ack <= pwrreq_s;
    end
  end

  // Register read data, one cycle after the strobe.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (req.read) begin
      rdata <= '0;
      case (req.addr)
        DEBUG_STATUS_OFS: begin
          rdata[STAT_AUTHENTICATION_FLAG_BIT]    <= authentication_flag; // [RULE_22]
          rdata[STAT_SLEEP_BIT]   <= sleep_s;
          rdata[STAT_CLKSTOP_BIT] <= erase_s || halted_s;
        end
        DEBUG_CONTROL_OFS: begin
          rdata[CTRL_HALT_BIT] <= external_halt_request;
          rdata[CTRL_WAKE_BIT] <= debug_interrupt_request;
        end
        POWER_STATUS_OFS: begin
          rdata[PWR_REQ_BIT] <= pwrreq_s;
          rdata[PWR_ACK_BIT] <= power_up_ack;
        end
        ACCESS_STATUS_OFS: rdata[0] <= ahb_port_enable; // [RULE_20]
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  property p_match_grants;
    @(posedge clock) disable iff (!reset_n)
    (wait_done && !compare_due_reg && match) |=> authentication_flag;
  endproperty
  a_match_grants: assert property (p_match_grants) // [RULE_01]
    else $error("key match did not grant");
  property p_msb_zero;
    @(posedge clock) disable iff (!reset_n)
    !unlock_reg[KEY_MSB] |=> !authentication_flag;
  endproperty
  a_msb_zero: assert property (p_msb_zero) // [RULE_14]
    else $error("blocked code granted access");
  property p_all_ones;
    @(posedge clock) disable iff (!reset_n)
    (!compare_due_reg && unlock_reg == UNLOCK_CODE_RESET) |=> authentication_flag;
  endproperty
  a_all_ones: assert property (p_all_ones) // [RULE_15]
    else $error("all-ones code did not grant");
  property p_wait;
    @(posedge clock) disable iff (!reset_n)
    !wait_done |=> !authentication_flag;
  endproperty
  a_wait: assert property (p_wait) // [RULE_13]
    else $error("result before startup wait");
  property p_sw_reset;
    @(posedge clock) disable iff (!reset_n)
    key_written_reg |=> !sw_reset_out;
  endproperty
  a_sw_reset: assert property (p_sw_reset) // [RULE_11]
    else $error("software reset passed after key write");
  property p_bus;
    @(posedge clock) disable iff (!reset_n)
    !bus_ok |=> !system_bus_enable;
  endproperty
  a_bus: assert property (p_bus) // [RULE_09]
    else $error("bus open in blocked mode");
  property p_entry;
    @(posedge clock) disable iff (!reset_n)
    (!debug_mode && !entry_ok) |=> !debug_mode;
  endproperty
  a_entry: assert property (p_entry) // [RULE_04]
    else $error("debug entered in forbidden mode");
  property p_port;
    @(posedge clock) disable iff (!reset_n)
    authentication_flag |=> ahb_port_enable == $past(authentication_flag);
  endproperty
  a_port: assert property (p_port) // [RULE_20]
    else $error("port status differs from flag");
  property p_halt;
    @(posedge clock) disable iff (!reset_n)
    (halted_s && !wr_ctrl) |=> !external_halt_request;
  endproperty
  a_halt: assert property (p_halt) // [RULE_23]
    else $error("halt request not cleared");
  c_grant: cover property (@(posedge clock) disable iff (!reset_n) $rose(authentication_flag));
  c_bus: cover property (@(posedge clock) disable iff (!reset_n) $rose(system_bus_enable));
  c_wake: cover property (@(posedge clock) disable iff (!reset_n) wake_without_execute);
endmodule : debug_access_authentication
`default_nettype wire

// ===== core/dbg_authentication_flag_pkg.sv
package dbg_authentication_flag_pkg;

  localparam int          KEY_WIDTH      = 128;
  localparam int          WORD_WIDTH     = 32;
  localparam int          ADDR_WIDTH     = 12;
  localparam int          KEY_WORDS      = 4;
  localparam int          KEY_MSB        = 127;

  // Register offsets in the debug-only register space.
  localparam logic [11:0] KEY_ENTRY_WORD0_OFS = 12'h000;
  localparam logic [11:0] KEY_ENTRY_WORD1_OFS = 12'h100;
  localparam logic [11:0] KEY_ENTRY_WORD2_OFS = 12'h200;
  localparam logic [11:0] KEY_ENTRY_WORD3_OFS = 12'h300;
  localparam logic [11:0] DEBUG_STATUS_OFS    = 12'h400;
  localparam logic [11:0] DEBUG_CONTROL_OFS   = 12'h410;
  localparam logic [11:0] POWER_STATUS_OFS    = 12'h420;
  localparam logic [11:0] ACCESS_STATUS_OFS   = 12'h430;

  // Field positions.
  localparam int          STAT_AUTHENTICATION_FLAG_BIT    = 0;
  localparam int          STAT_SLEEP_BIT   = 1;
  localparam int          STAT_CLKSTOP_BIT = 2;
  localparam int          CTRL_HALT_BIT    = 0;
  localparam int          CTRL_WAKE_BIT    = 8;
  localparam int          PWR_REQ_BIT      = 28;
  localparam int          PWR_ACK_BIT      = 29;

  // Reset values and the erase key.
  localparam logic [31:0]  KEY_WORD_RESET    = 32'hFFFFFFFF;
  localparam logic [127:0] UNLOCK_CODE_RESET = 128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF;
  localparam logic [127:0] ERASE_KEY         = 128'h414C6552415345FFFFFFFFFFFFFFFFFF;

  // Wait after reset release before comparing.
  localparam int          COMPARE_WAIT_NS  = 1000;
  localparam int          CLOCK_PERIOD_NS  = 40;
  localparam int          COMPARE_WAIT_CYC = (COMPARE_WAIT_NS + CLOCK_PERIOD_NS - 1)
                                             / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {PCM_BOOST, PCM_NORMAL, PCM_BACK_BIAS} power_ctrl_e;
  typedef enum logic [1:0] {PSM_ALL_POWER_ON, PSM_PARTIAL, PSM_MINIMUM} supply_e;
  typedef enum logic [2:0] {LPM_OPERATING, LPM_SLEEP, LPM_SNOOZE, LPM_STANDBY,
                            LPM_DEEP_STANDBY} low_power_e;

  typedef struct packed {
    power_ctrl_e power_ctrl;
    supply_e     supply;
    low_power_e  low_power;
    logic        in_transition;
  } chip_mode_s;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } reg_req_s;

endpackage : dbg_authentication_flag_pkg

// ===== core/dbg_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a group of levels from outside the clock domain.
module dbg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : dbg_sync
`default_nettype wire

// ===== core/dbg_mode_gate.sv
`timescale 1ns/1ps
`default_nettype none
// Decides from the chip's mode whether debug entry and system bus access are allowed.
module dbg_mode_gate
  import dbg_authentication_flag_pkg::*;
(
  input  wire dbg_authentication_flag_pkg::chip_mode_s mode,
  output logic                          entry_ok,
  output logic                          bus_ok
);
  always_comb begin
    entry_ok = 1'b0;
    bus_ok   = 1'b0;
    if (!mode.in_transition &&
        (mode.low_power == LPM_OPERATING || mode.low_power == LPM_SLEEP)) begin
      entry_ok = (mode.power_ctrl == PCM_BOOST) ||
                 (mode.power_ctrl == PCM_NORMAL && mode.supply == PSM_ALL_POWER_ON);
      bus_ok   = 1'b1;
    end
  end
endmodule : dbg_mode_gate
`default_nettype wire

// ===== verif/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// Probe power-up handshake on the link clock, plus CPU halt and flash erase responses.
module far_side_model #(
  parameter int HALT_DELAY  = 3,
  parameter int ERASE_DELAY = 6
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic link_clock,
  input  wire logic connect,
  input  wire logic power_up_ack,
  input  wire logic external_halt_request,
  input  wire logic erase_start,
  output logic      power_up_request,
  output logic      link_up,
  output logic      cpu_halted,
  output logic      erase_done
);
  int halt_cnt;
  int erase_cnt;

  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n)
      power_up_request <= 1'b0;
    else
      power_up_request <= connect;
  end

  // The bus is only used once the acknowledge answers the request.
  assign link_up = power_up_request && power_up_ack;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      halt_cnt   <= 0;
      cpu_halted <= 1'b0;
    end else if (external_halt_request && !cpu_halted) begin
      halt_cnt   <= halt_cnt + 1;
      cpu_halted <= (halt_cnt == HALT_DELAY);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      erase_cnt  <= 0;
      erase_done <= 1'b0;
    end else if (erase_start || erase_cnt != 0) begin
      erase_cnt  <= erase_cnt + 1;
      erase_done <= erase_done || (erase_cnt == ERASE_DELAY);
    end
  end
endmodule : far_side_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dbg_authentication_flag_pkg::*;
  localparam logic [127:0] KEY     = 128'h8123456789ABCDEF02468ACE13579BDF;
  localparam logic [127:0] KEY_BLK = {1'b0, KEY[126:0]};
  localparam chip_mode_s ENTRY [5] = '{'{PCM_NORMAL, PSM_PARTIAL, LPM_OPERATING, 1'b0},
    '{PCM_BACK_BIAS, PSM_ALL_POWER_ON, LPM_OPERATING, 1'b0},
    '{PCM_NORMAL, PSM_ALL_POWER_ON, LPM_SNOOZE, 1'b0},
    '{PCM_BOOST, PSM_ALL_POWER_ON, LPM_OPERATING, 1'b1},
    '{PCM_NORMAL, PSM_ALL_POWER_ON, LPM_SLEEP, 1'b0}};
  localparam chip_mode_s BUS [6] = '{'{PCM_BOOST, PSM_ALL_POWER_ON, LPM_OPERATING, 1'b0},
    '{PCM_NORMAL, PSM_ALL_POWER_ON, LPM_SNOOZE, 1'b0},
    '{PCM_BACK_BIAS, PSM_ALL_POWER_ON, LPM_SLEEP, 1'b0},
    '{PCM_NORMAL, PSM_ALL_POWER_ON, LPM_STANDBY, 1'b0},
    '{PCM_NORMAL, PSM_ALL_POWER_ON, LPM_OPERATING, 1'b1},
    '{PCM_BACK_BIAS, PSM_MINIMUM, LPM_DEEP_STANDBY, 1'b0}};
  localparam logic [5:0] BUS_OK = 6'h05;
  localparam power_ctrl_e CHG_FROM [3] = '{PCM_BOOST, PCM_NORMAL, PCM_NORMAL};
  localparam power_ctrl_e CHG_TO [3]   = '{PCM_NORMAL, PCM_BOOST, PCM_BACK_BIAS};
  logic        clock, link_clock;
  logic        reset_n = 1'b0, connect = 1'b0, program_pending = 1'b0, cpu_sleeping = 1'b0;
  logic        sw_reset_request = 1'b0, mode_change_request = 1'b0, debug_entry_request = 1'b0;
  logic        debugger_enable = 1'b0;
  reg_req_s    req = '0;
  logic [127:0] programmed_code = '0;
  power_ctrl_e mode_change_target = PCM_BOOST;
  chip_mode_s  mode = '{PCM_BOOST, PSM_ALL_POWER_ON, LPM_OPERATING, 1'b0};
  logic [31:0] rdata;
  logic        cpu_halted, erase_done, power_up_request, link_up, debug_mode;
  logic        authentication_flag, ahb_port_enable, system_bus_enable, external_halt_request;
  logic        debug_interrupt_request, wake_without_execute, power_up_ack, sw_reset_out;
  logic        mode_change_grant, erase_start, keep_normal_power;
  int          err_count = 0, checks_done = 0, cyc = 0, erase_pulses = 0;

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    forever #160 link_clock = ~link_clock;
  end

  debug_access_authentication u_dut (
    .clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
    .programmed_code(programmed_code), .program_pending(program_pending),
    .cpu_sleeping(cpu_sleeping), .cpu_halted(cpu_halted), .erase_done(erase_done),
    .power_up_request(power_up_request), .sw_reset_request(sw_reset_request),
    .mode_change_request(mode_change_request), .mode_change_target(mode_change_target),
    .mode(mode), .debug_entry_request(debug_entry_request), .debug_mode(debug_mode),
    .authentication_flag(authentication_flag), .ahb_port_enable(ahb_port_enable),
    .system_bus_enable(system_bus_enable), .external_halt_request(external_halt_request),
    .debug_interrupt_request(debug_interrupt_request),
    .wake_without_execute(wake_without_execute), .power_up_ack(power_up_ack),
    .sw_reset_out(sw_reset_out), .mode_change_grant(mode_change_grant),
    .erase_start(erase_start), .keep_normal_power(keep_normal_power));

  far_side_model u_far (
    .clock(clock), .reset_n(reset_n), .link_clock(link_clock), .connect(connect),
    .power_up_ack(power_up_ack), .external_halt_request(external_halt_request),
    .erase_start(erase_start), .power_up_request(power_up_request), .link_up(link_up),
    .cpu_halted(cpu_halted), .erase_done(erase_done));

  task automatic ck(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : ck

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    req.write <= 1'b0;
  endtask : wr

  task automatic rc(input string name, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    req <= '{a, 32'h00000000, 1'b0, 1'b1};
    @(posedge clock);
    req.read <= 1'b0;
    #1;
    ck(name, rdata, exp);
  endtask : rc

  task automatic write_key(input logic [127:0] k);
    for (int i = 0; i < KEY_WORDS; i++) wr(12'(i * 256), k[127 - 32 * i -: 32]);
    cycles(3);
  endtask : write_key

  task automatic set_mode(input chip_mode_s m);
    @(posedge clock);
    mode <= m;
    cycles(5);
  endtask : set_mode

  task automatic do_reset();
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    ck("authentication_flag_in_reset", 32'(authentication_flag), 32'h00000000);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (erase_start === 1'b1) erase_pulses++;
    if (cyc == 6000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    do_reset();
    cycles(20);
    ck("authentication_flag_early", 32'(authentication_flag), 32'h00000000);
    cycles(10);
    ck("authentication_flag_keyless", 32'(authentication_flag), 32'h00000001);
    ck("ahb_keyless", 32'(ahb_port_enable), 32'h00000001);
    sw_reset_request <= 1'b1;
    cycles(5);
    ck("sw_reset_free", 32'(sw_reset_out), 32'h00000001);
    sw_reset_request <= 1'b0;
    programmed_code <= KEY;
    program_pending <= 1'b1;
    connect <= 1'b1;
    cycles(40);
    ck("authentication_flag_code_held", 32'(authentication_flag), 32'h00000001);
    ck("link_up", 32'(link_up), 32'h00000001);
    rc("power_status", POWER_STATUS_OFS, 32'h30000000);
    write_key(KEY);
    do_reset();
    cycles(30);
    ck("authentication_flag_new_code", 32'(authentication_flag), 32'h00000000);
    write_key(KEY ^ 128'h1);
    ck("authentication_flag_bit_off", 32'(authentication_flag), 32'h00000000);
    cpu_sleeping <= 1'b1;
    write_key(KEY);
    ck("authentication_flag_match", 32'(authentication_flag), 32'h00000001);
    ck("ahb_match", 32'(ahb_port_enable), 32'h00000001);
    debugger_enable <= 1'b1;
    rc("status", DEBUG_STATUS_OFS, 32'h00000003);
    rc("unmapped", 12'h7F0, 32'h00000000);
    sw_reset_request <= 1'b1;
    cycles(5);
    ck("sw_reset_blocked", 32'(sw_reset_out), 32'h00000000);
    sw_reset_request <= 1'b0;
    write_key(~KEY);
    ck("authentication_flag_rewrite", 32'(authentication_flag), 32'h00000000);
    ck("ahb_rewrite", 32'(ahb_port_enable), 32'h00000000);
    write_key(KEY);
    for (int i = 0; i < 5; i++) begin
      set_mode(ENTRY[i]);
      debug_entry_request <= 1'b1;
      cycles(5);
      ck("debug_entry", 32'(debug_mode), 32'(i == 4));
      debug_entry_request <= 1'b0;
    end
    for (int i = 0; i < 6; i++) begin
      set_mode(BUS[i]);
      ck("bus_access", 32'(system_bus_enable), 32'(BUS_OK[i]));
      ck("debug_kept", 32'(debug_mode), 32'h00000001);
    end
    for (int i = 0; i < 3; i++) begin
      set_mode('{CHG_FROM[i], PSM_ALL_POWER_ON, LPM_OPERATING, 1'b0});
      mode_change_target <= CHG_TO[i];
      mode_change_request <= 1'b1;
      cycles(5);
      ck("mode_change", 32'(mode_change_grant), 32'(i == 2));
      mode_change_request <= 1'b0;
    end
    set_mode('{PCM_BACK_BIAS, PSM_ALL_POWER_ON, LPM_OPERATING, 1'b0});
    ck("keep_normal", 32'(keep_normal_power), 32'h00000001);
    set_mode('{PCM_NORMAL, PSM_ALL_POWER_ON, LPM_STANDBY, 1'b0});
    cpu_sleeping <= 1'b0;
    wr(DEBUG_CONTROL_OFS, 32'h00000101);
    cycles(2);
    ck("wake_req", 32'(debug_interrupt_request), 32'h00000001);
    ck("wake_no_run", 32'(wake_without_execute), 32'h00000001);
    ck("halt_req", 32'(external_halt_request), 32'h00000001);
    cycles(20);
    ck("halt_clear", 32'(external_halt_request), 32'h00000000);
    rc("control", DEBUG_CONTROL_OFS, 32'h00000100);
    rc("status_halt", DEBUG_STATUS_OFS, 32'h00000005);
    wr(DEBUG_CONTROL_OFS, 32'h00000000);
    cycles(3);
    ck("wake_off", 32'(debug_interrupt_request), 32'h00000000);
    programmed_code <= KEY_BLK;
    write_key(KEY_BLK);
    do_reset();
    cycles(30);
    write_key(KEY_BLK);
    ck("authentication_flag_blocked", 32'(authentication_flag), 32'h00000000);
    ck("ahb_blocked", 32'(ahb_port_enable), 32'h00000000);
    programmed_code <= ERASE_KEY;
    write_key(ERASE_KEY);
    erase_pulses = 0;
    do_reset();
    cycles(60);
    ck("erase_pulses", erase_pulses, 32'h00000001);
    rc("status_erased", DEBUG_STATUS_OFS, 32'h00000004);
    program_pending <= 1'b0;
    do_reset();
    cycles(30);
    ck("authentication_flag_erased", 32'(authentication_flag), 32'h00000001);
    debugger_enable <= 1'b0;
    finish_test();
  end
endmodule : tb
`default_nettype wire
